// ===== dcbp_top.sv
// Purpose: Downstream cell bus front end: poll answers and segment status.
// Assumes: All cell bus inputs synchronous to clk_i; master keeps its own rules.
// Notes:   Segment drain is signalled by software clearing full bits.
//
// The Avalon-MM slave port and the register addresses were left to the implementer.

module dcbp_top
   import dcbp_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 ce_i,
   // Cell bus from the scheduler
   input  wire logic                 tx_start_of_cell_i,
   input  wire logic                 tx_write_enable_n_i,
   input  wire logic [ADDR_W-1:0]    tx_poll_address_i,
   input  wire logic                 tx_data_parity_i,
   input  wire logic [DATA_W-1:0]    tx_cell_data_i,
   // Cell space available, three-state
   output      logic                 tx_cell_space_available_o,
   output      logic                 tx_cell_space_available_oe_o,
   // Captured cell words
   output      dcbp_word_t           word_o,
   output      logic                 word_valid_o,
   input  wire logic                 word_ready_i,
   // Avalon-MM register slave
   input  wire logic [3:0]           avs_address_i,
   input  wire logic                 avs_read_i,
   input  wire logic                 avs_write_i,
   input  wire logic [31:0]          avs_writedata_i,
   input  wire logic [3:0]           avs_byteenable_i,
   output      logic [31:0]          avs_readdata_o,
   output      logic                 avs_waitrequest_o
);

   // ==========================================================================
   // Declarations
   dcbp_bus_t        cap_q;
   logic             cap_v;
   logic             tpa_q;
   logic             tpa_oe_q;
   logic             next_tpa;
   logic             next_tpa_oe;
   logic             delay_sel;
   logic [8:0]       ctrl_base;
   logic [8:0]       lc_base;
   logic [1:0]       lc_range;
   logic [SEG_N-1:0] seg_full;
   logic             ovf;
   logic             wait_q;
   logic [31:0]      rdata_q;
   logic             next_delay_sel;
   logic [8:0]       next_ctrl_base;
   logic [8:0]       next_lc_base;
   logic [1:0]       next_lc_range;
   logic [SEG_N-1:0] next_seg_full;
   logic             next_ovf;
   logic             next_wait;
   logic [31:0]      next_rdata;
   dcbp_cell_state_t cell_st;
   dcbp_cell_state_t next_cell_st;
   logic [4:0]       word_cnt;
   logic [4:0]       next_word_cnt;
   logic [SEG_W-1:0] cell_seg;
   logic [SEG_W-1:0] next_cell_seg;
   logic             pend;
   logic             next_pend;
   logic [3:0]       dly_cnt;
   logic [3:0]       next_dly_cnt;
   logic [SEG_W-1:0] pend_seg;
   logic [SEG_W-1:0] next_pend_seg;
   logic             buf_ready;
   logic             word_in;
   logic             cell_start;
   logic             cell_done;
   logic             dly_fire;
   logic             wr_acc;
   logic [31:0]      wmask;
   logic [8:0]       lc_off;
   logic             hit;
   dcbp_word_t       buf_in;

   // ==========================================================================
   // Input capture; reset idles write enable, so no false word
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cap_q <= '{wen_n: 1'b1, default: '0};
         cap_v <= 1'b0;
      end else if (ce_i) begin
         cap_q <= {tx_start_of_cell_i, tx_write_enable_n_i, tx_poll_address_i,
                   tx_data_parity_i, tx_cell_data_i};
         cap_v <= 1'b1;
      end
   end

   // ==========================================================================
   // Poll answer from the captured address
   // Full buffer also reports no space; a word written while it is full sets ovf
   always_comb begin
      lc_off      = cap_q.addr[11:3] - lc_base;
      hit         = (cap_q.addr[11:3] == ctrl_base) ||
                    (lc_off <= {7'h00, lc_range});
      next_tpa_oe = hit && cap_v;
      next_tpa    = !seg_full[cap_q.addr[SEG_W-1:0]] && buf_ready;
   end

   // Second stage gives the two-cycle latency
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tpa_q    <= 1'b0;
         tpa_oe_q <= 1'b0;
      end else if (ce_i) begin
         tpa_q    <= next_tpa;
         tpa_oe_q <= next_tpa_oe;
      end
   end

   // ==========================================================================
   // Cell tracking and delayed status refresh
   // Stale status is allowed while a refresh is pending
   always_comb begin
      word_in       = !cap_q.wen_n;
      cell_start    = word_in && cap_q.sox;
      cell_done     = 1'b0;
      next_cell_st  = cell_st;
      next_word_cnt = word_cnt;
      next_cell_seg = cell_seg;
      if (cell_start) begin
         next_cell_st  = CELL_BUSY;
         next_word_cnt = 5'h01;
         next_cell_seg = cap_q.data[SEG_W-1:0];
      end else if (word_in && cell_st == CELL_BUSY) begin
         next_word_cnt = word_cnt + 5'h01;
         if (word_cnt == CELL_WORDS - 5'h01) begin
            cell_done    = 1'b1;
            next_cell_st = CELL_IDLE;
         end
      end
      dly_fire      = pend && (dly_cnt == 4'h1);
      next_pend     = pend;
      next_dly_cnt  = dly_cnt;
      next_pend_seg = pend_seg;
      if (cell_done && delay_sel) begin
         next_pend     = 1'b1;
         next_dly_cnt  = STATUS_DELAY_CYCLES;
         next_pend_seg = cell_seg;
      end else if (dly_fire) begin
         next_pend = 1'b0;
      end else if (pend) begin
         next_dly_cnt = dly_cnt - 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cell_st  <= CELL_IDLE;
         word_cnt <= 5'h00;
         cell_seg <= SEG_IDX_RST;
         pend     <= 1'b0;
         dly_cnt  <= 4'h0;
         pend_seg <= SEG_IDX_RST;
      end else if (ce_i) begin
         cell_st  <= next_cell_st;
         word_cnt <= next_word_cnt;
         cell_seg <= next_cell_seg;
         pend     <= next_pend;
         dly_cnt  <= next_dly_cnt;
         pend_seg <= next_pend_seg;
      end
   end

   // ==========================================================================
   // Word buffer toward the cell store
   assign buf_in = {cap_q.sox, cap_q.par, cap_q.data};

   dcbp_skid2 u_buf (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .ce_i        (ce_i),
      .in_word_i   (buf_in),
      .in_valid_i  (word_in),
      .in_ready_o  (buf_ready),
      .out_word_o  (word_o),
      .out_valid_o (word_valid_o),
      .out_ready_i (word_ready_i)
   );

   // ==========================================================================
   // Register slave: one wait cycle, then answer; writes land on accept edge
   always_comb begin
      wr_acc         = avs_write_i && !wait_q;
      wmask          = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                        {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
      next_wait      = !((avs_read_i || avs_write_i) && wait_q);
      next_rdata     = rdata_q;
      next_delay_sel = delay_sel;
      next_ctrl_base = ctrl_base;
      next_lc_base   = lc_base;
      next_lc_range  = lc_range;
      next_seg_full  = seg_full;
      next_ovf       = ovf;
      if (avs_read_i && wait_q) begin
         unique case (avs_address_i)
            REG_CONFIG:   next_rdata = {31'h0, delay_sel};
            REG_BASES:    next_rdata = {2'h0, lc_range, 3'h0, lc_base,
                                        7'h00, ctrl_base};
            REG_SEG_FULL: next_rdata = seg_full;
            REG_STATUS:   next_rdata = {21'h0, ovf, cell_st == CELL_BUSY,
                                        pend, 3'h0, pend_seg};
            default:      next_rdata = 32'h0;  // Unmapped reads as zero
         endcase
      end
      if (wr_acc) begin
         unique case (avs_address_i)
            REG_CONFIG: begin
               if (avs_byteenable_i[0]) begin
                  next_delay_sel = avs_writedata_i[CFG_DELAY_BIT];
               end
            end
            REG_BASES: begin
               if (avs_byteenable_i[0]) begin
                  next_ctrl_base[7:0] = avs_writedata_i[BASE_CTRL_LSB +: 8];
               end
               if (avs_byteenable_i[1]) begin
                  next_ctrl_base[8] = avs_writedata_i[BASE_CTRL_LSB + 8];
               end
               if (avs_byteenable_i[2]) begin
                  next_lc_base[7:0] = avs_writedata_i[BASE_LC_LSB +: 8];
               end
               if (avs_byteenable_i[3]) begin
                  next_lc_base[8] = avs_writedata_i[BASE_LC_LSB + 8];
                  next_lc_range   = avs_writedata_i[BASE_RANGE_LSB +: 2];
               end
            end
            REG_SEG_FULL: next_seg_full = seg_full & ~(avs_writedata_i & wmask);
            REG_STATUS: begin
               if (avs_byteenable_i[1] && avs_writedata_i[STAT_OVF_BIT]) begin
                  next_ovf = 1'b0;
               end
            end
            default: ;  // Unmapped writes ignored
         endcase
      end
      // Hardware sets after software clears, so a set in the same cycle wins
      if (cell_start && !delay_sel) begin
         next_seg_full[cap_q.data[SEG_W-1:0]] = 1'b1;
      end
      if (dly_fire) begin
         next_seg_full[pend_seg] = 1'b1;
      end
      if (word_in && !buf_ready) begin
         next_ovf = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wait_q    <= 1'b1;
         rdata_q   <= 32'h0;
         delay_sel <= DELAY_SEL_RST;
         ctrl_base <= CTRL_BASE_RST;
         lc_base   <= LC_BASE_RST;
         lc_range  <= RANGE_RST;
         seg_full  <= '0;
         ovf       <= 1'b0;
      end else if (ce_i) begin
         wait_q    <= next_wait;
         rdata_q   <= next_rdata;
         delay_sel <= next_delay_sel;
         ctrl_base <= next_ctrl_base;
         lc_base   <= next_lc_base;
         lc_range  <= next_lc_range;
         seg_full  <= next_seg_full;
         ovf       <= next_ovf;
      end
   end

   // ==========================================================================
   // Outputs, all straight from flops
   assign tx_cell_space_available_o    = tpa_q;
   assign tx_cell_space_available_oe_o = tpa_oe_q;
   assign avs_readdata_o               = rdata_q;
   assign avs_waitrequest_o            = wait_q;

endmodule : dcbp_top

// ===== dcbp_pkg.sv
// Purpose: Shared constants and types for the downstream cell bus polling block.
// Assumes: One clock, synchronous active-low reset, Avalon-MM register slave.
// Notes:   Register offsets are byte addresses, one aligned 32-bit word each.
package dcbp_pkg;

   // ==========================================================================
   // Widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int SEG_N  = 32;
   localparam int SEG_W  = 5;

   // ==========================================================================
   // Register offsets (byte addresses)
   localparam logic [3:0] REG_CONFIG   = 4'h0;
   localparam logic [3:0] REG_BASES    = 4'h4;
   localparam logic [3:0] REG_SEG_FULL = 4'h8;
   localparam logic [3:0] REG_STATUS   = 4'hc;

   // ==========================================================================
   // Field positions
   localparam int CFG_DELAY_BIT   = 0;
   localparam int BASE_CTRL_LSB   = 0;
   localparam int BASE_LC_LSB     = 16;
   localparam int BASE_RANGE_LSB  = 28;
   localparam int STAT_PEND_LSB   = 0;
   localparam int STAT_PEND_BIT   = 8;
   localparam int STAT_INCELL_BIT = 9;
   localparam int STAT_OVF_BIT    = 10;

   // ==========================================================================
   // Reset values
   localparam logic       DELAY_SEL_RST = 1'b0;
   localparam logic [8:0] CTRL_BASE_RST = 9'h1ff;
   localparam logic [8:0] LC_BASE_RST   = 9'h000;
   localparam logic [1:0] RANGE_RST     = 2'h3;
   localparam logic [4:0] SEG_IDX_RST   = 5'h00;

   // ==========================================================================
   // Timing counts (transmit cell-bus clock cycles)
   localparam logic [4:0] CELL_WORDS          = 5'h1a;  // 26 words per cell
   localparam logic [3:0] STATUS_DELAY_CYCLES = 4'h9;   // Delayed refresh

   // ==========================================================================
   // Types
   typedef struct packed {
      logic              sox;
      logic              wen_n;
      logic [ADDR_W-1:0] addr;
      logic              par;
      logic [DATA_W-1:0] data;
   } dcbp_bus_t;

   typedef struct packed {
      logic              sox;
      logic              par;
      logic [DATA_W-1:0] data;
   } dcbp_word_t;

   typedef enum logic {
      CELL_IDLE = 1'b0,
      CELL_BUSY = 1'b1
   } dcbp_cell_state_t;

endpackage : dcbp_pkg

// ===== dcbp_skid2.sv
// Purpose: Two-entry valid/ready buffer in the cell word path.
// Assumes: Synchronous active-low reset, clock enable freezes all state.
// Notes:   All outputs come from flops; in_ready drops only when both entries hold.
module dcbp_skid2
   import dcbp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   // Fill side
   input  wire dcbp_word_t  in_word_i,
   input  wire logic        in_valid_i,
   output      logic        in_ready_o,
   // Drain side
   output      dcbp_word_t  out_word_o,
   output      logic        out_valid_o,
   input  wire logic        out_ready_i
);

   dcbp_word_t out_q;
   dcbp_word_t skid_q;
   logic       out_v;
   logic       skid_v;
   dcbp_word_t next_out_q;
   dcbp_word_t next_skid_q;
   logic       next_out_v;
   logic       next_skid_v;

   // ==========================================================================
   // Next state: skid entry catches the word that arrives during a stall
   always_comb begin
      next_out_q  = out_q;
      next_out_v  = out_v;
      next_skid_q = skid_q;
      next_skid_v = skid_v;
      if (out_ready_i || !out_v) begin
         if (skid_v) begin
            next_out_q  = skid_q;
            next_out_v  = 1'b1;
            next_skid_v = 1'b0;
         end else begin
            next_out_q = in_word_i;
            next_out_v = in_valid_i;
         end
      end else if (in_valid_i && !skid_v) begin
         next_skid_q = in_word_i;
         next_skid_v = 1'b1;
      end
   end

   // ==========================================================================
   // Registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         out_q  <= '0;
         out_v  <= 1'b0;
         skid_q <= '0;
         skid_v <= 1'b0;
      end else if (ce_i) begin
         out_q  <= next_out_q;
         out_v  <= next_out_v;
         skid_q <= next_skid_q;
         skid_v <= next_skid_v;
      end
   end

   assign out_word_o  = out_q;
   assign out_valid_o = out_v;
   assign in_ready_o  = !skid_v;  // Flop output, inverted only

endmodule : dcbp_skid2

// ===== dcbp_chk_sva.sv
// Purpose: Assertions on the poll answer and register bus of dcbp_top.
// Assumes: Base register written with all lanes; ce_i held high.
// Notes:   Mirrors the base register to know the polled window.
module dcbp_chk
   import dcbp_pkg::*;
(
   // Clock and reset
   input wire logic              clk_i,
   input wire logic              rst_n_i,
   // Poll side
   input wire logic [ADDR_W-1:0] tx_poll_address_i,
   input wire logic              tx_cell_space_available_oe_o,
   // Buffered words
   input wire dcbp_word_t        word_o,
   input wire logic              word_valid_o,
   input wire logic              word_ready_i,
   // Register bus
   input wire logic [3:0]        avs_address_i,
   input wire logic              avs_read_i,
   input wire logic              avs_write_i,
   input wire logic [31:0]       avs_writedata_i,
   input wire logic [31:0]       avs_readdata_o,
   input wire logic              avs_waitrequest_o
);
   // ==========================================================================
   // Base mirror
   logic [8:0] ctl_b, lc_b, next_ctl_b, next_lc_b;
   logic [1:0] rng_b, next_rng_b;
   logic       hit;
   wire logic  oe = tx_cell_space_available_oe_o;
   wire logic  wt = avs_waitrequest_o;
   // Accepted writes only
   always_comb begin
      {next_ctl_b, next_lc_b, next_rng_b} = {ctl_b, lc_b, rng_b};
      if (avs_write_i && !wt && avs_address_i == REG_BASES) begin
         next_ctl_b = avs_writedata_i[BASE_CTRL_LSB +: 9];
         next_lc_b  = avs_writedata_i[BASE_LC_LSB +: 9];
         next_rng_b = avs_writedata_i[BASE_RANGE_LSB +: 2];
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         {ctl_b, lc_b, rng_b} <= {CTRL_BASE_RST, LC_BASE_RST, RANGE_RST};
      end else begin
         {ctl_b, lc_b, rng_b} <= {next_ctl_b, next_lc_b, next_rng_b};
      end
   end
   // Upper address window
   assign hit = (tx_poll_address_i[11:3] == ctl_b) || (tx_poll_address_i[11:3] >= lc_b
                && {1'b0, tx_poll_address_i[11:3]} <= {1'b0, lc_b} + 10'(rng_b));

   // ==========================================================================
   // Properties
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_hit_drive; hit |-> ##2 oe; endproperty
   a_hit_drive: assert property (p_hit_drive) else $error("hit poll not driven");
   property p_miss_float; !hit |-> ##2 !oe; endproperty
   a_miss_float: assert property (p_miss_float) else $error("miss poll driven");
   property p_rst_float; $rose(rst_n_i) |-> !oe ##1 !oe; endproperty
   a_rst_float: assert property (p_rst_float) else $error("driven after reset");
   property p_b2b; hit ##1 !hit |-> ##1 oe ##1 !oe; endproperty
   a_b2b: assert property (p_b2b) else $error("pipelined answer lost");
   property p_wait_one; (avs_read_i || avs_write_i) && wt |=> !wt; endproperty
   a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");
   property p_wait_pulse; !wt |=> wt; endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
   property p_word_hold; word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o);
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("stalled word changed");
   property p_unmapped;
      avs_read_i && !wt && avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   c_b2b: cover property (hit ##1 !hit ##1 oe);
   c_stall: cover property (word_valid_o && !word_ready_i);
   c_read: cover property (avs_read_i && !wt);
endmodule : dcbp_chk

bind dcbp_top dcbp_chk dcbp_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .tx_poll_address_i(tx_poll_address_i),
   .tx_cell_space_available_oe_o(tx_cell_space_available_oe_o),
   .word_o(word_o), .word_valid_o(word_valid_o), .word_ready_i(word_ready_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o));

// ===== dcbp_sched_model.sv
// Purpose: Scheduler model that polls and writes cells on the cell bus.
// Assumes: Tasks are called right after a rising edge of clk_i.
// Notes:   Idle data lines toggle so a stale word is never mistaken.
module dcbp_sched_model
   import dcbp_pkg::*;
(
   // Clock
   input  wire logic              clk_i,
   // Cell bus toward the device
   output      logic              tx_start_of_cell_o,
   output      logic              tx_write_enable_n_o,
   output      logic [ADDR_W-1:0] tx_poll_address_o,
   output      logic              tx_data_parity_o,
   output      logic [DATA_W-1:0] tx_cell_data_o,
   // Marks a poll cycle for the bench
   output      logic              poll_v_o
);
   // ==========================================================================
   // Idle values, address chosen to miss every window used
   localparam logic [ADDR_W-1:0] IDLE_ADDR = 12'hf00;
   initial begin
      {tx_start_of_cell_o, tx_write_enable_n_o, tx_data_parity_o, poll_v_o} = 4'h4;
      tx_poll_address_o = IDLE_ADDR;
      tx_cell_data_o = 16'h0000;
   end
   // One word; start flag only on the first word of a cell
   task automatic put_word(input logic sox, input logic par, input logic [15:0] d);
      tx_start_of_cell_o <= sox;
      tx_write_enable_n_o <= 1'b0;
      tx_data_parity_o <= par;
      tx_cell_data_o <= d;
      @(posedge clk_i);
   endtask : put_word
   // Pause: no word, data lines toggled
   task automatic pause();
      {tx_start_of_cell_o, tx_write_enable_n_o} <= 2'h1;
      tx_cell_data_o <= ~tx_cell_data_o;
      tx_data_parity_o <= ~tx_data_parity_o;
      @(posedge clk_i);
   endtask : pause
   task automatic poll(input logic [ADDR_W-1:0] a);
      tx_poll_address_o <= a;
      poll_v_o <= 1'b1;
      @(posedge clk_i);
   endtask : poll
   task automatic poll_done();
      tx_poll_address_o <= IDLE_ADDR;
      poll_v_o <= 1'b0;
   endtask : poll_done
endmodule : dcbp_sched_model

// ===== test_downstream_cell_bus_polling.sv
// Purpose: Self-checking bench for the downstream cell bus polling block.
// Assumes: ce_i held high.
// Notes:   Expected answers and words queue up; watchers pop and compare.
module test_downstream_cell_bus_polling;
   timeunit 1ns;
   timeprecision 1ps;
   import dcbp_pkg::*;
   // ==========================================================================
   // Signals
   logic              clk_i = 1'b0, rst_n_i = 1'b0, word_ready_i = 1'b1;
   logic [3:0]        avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
   logic              avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [31:0]       avs_writedata_i = 32'h0, avs_readdata_o, exp_full = 32'h0;
   logic              sox, wen_n, par, poll_v, oe, ans, word_valid_o, avs_waitrequest_o;
   logic              p1 = 1'b0, p2 = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] data;
   logic [1:0]        pe;
   dcbp_word_t        word_o;
   logic [8:0]        cb = CTRL_BASE_RST, lb = LC_BASE_RST;
   logic [1:0]        rg = RANGE_RST;
   logic [1:0]        pq[$];
   dcbp_word_t        wq[$];
   int                n_mismatch = 0, n_checks = 0;

   always #10 clk_i = ~clk_i;  // 50 MHz
   dcbp_sched_model dcbp_sched_model_inst (.clk_i(clk_i), .tx_start_of_cell_o(sox),
      .tx_write_enable_n_o(wen_n), .tx_poll_address_o(addr), .tx_data_parity_o(par),
      .tx_cell_data_o(data), .poll_v_o(poll_v));
   dcbp_top dcbp_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .tx_start_of_cell_i(sox), .tx_write_enable_n_i(wen_n), .tx_poll_address_i(addr),
      .tx_data_parity_i(par), .tx_cell_data_i(data), .tx_cell_space_available_o(ans),
      .tx_cell_space_available_oe_o(oe), .word_o(word_o), .word_valid_o(word_valid_o),
      .word_ready_i(word_ready_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o));

   // ==========================================================================
   // Helpers
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   function automatic logic hit_f(input logic [ADDR_W-1:0] a);
      return a[11:3] == cb || (a[11:3] >= lb && {1'b0, a[11:3]} <= {1'b0, lb} + 10'(rg));
   endfunction : hit_f
   // Bus cycle: held until waitrequest is seen low at an edge
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
      int  i;
      logic done;
      {avs_address_i, avs_writedata_i, avs_byteenable_i} <= {a, d, be};
      {avs_write_i, avs_read_i} <= {w, !w};
      done = 1'b0;
      for (i = 0; i < 50 && !done; i++) begin
         @(posedge clk_i);
         done = (avs_waitrequest_o === 1'b0);
      end
      q = avs_readdata_o;
      if (!done) begin
         n_mismatch++;
         end_sim();
      end
      {avs_write_i, avs_read_i} <= 2'h0;
      @(posedge clk_i);
   endtask : av
   task automatic do_poll(input logic [ADDR_W-1:0] a, input logic stall);
      pq.push_back({hit_f(a), hit_f(a) && !exp_full[a[4:0]] && !stall});
      dcbp_sched_model_inst.poll(a);
   endtask : do_poll
   // Cell of 26 words, paused midway
   task automatic send_cell(input logic [4:0] seg, input logic keep);
      dcbp_word_t w;
      int k;
      for (k = 0; k < 26; k++) begin
         w = {k == 0, 1'($urandom), (k == 0) ? {11'($urandom), seg} : 16'($urandom)};
         if (keep || k < 2) wq.push_back(w);
         if (k == 13) dcbp_sched_model_inst.pause();
         dcbp_sched_model_inst.put_word(w.sox, w.par, w.data);
      end
      dcbp_sched_model_inst.pause();
   endtask : send_cell

   // ==========================================================================
   // Watchers on pre-edge values
   always @(posedge clk_i) begin
      p1 <= poll_v;
      p2 <= p1;
      if (p2) begin
         pe = pq.pop_front();
         chk("poll_drive", pe[1], oe);
         if (pe[1]) chk("poll_answer", pe[0], ans);
      end
      if (word_valid_o === 1'b1 && word_ready_i === 1'b1) begin
         chk("cell_word", 32'(wq.pop_front()), 32'(word_o));
      end
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      end_sim();
   end

   // ==========================================================================
   // Main sequence
   initial begin
      logic [31:0] q;
      logic [31:0] rx [5];
      logic [3:0]  ra [5];
      logic [8:0]  ups [2][7];
      int          k;
      q = $urandom(32'h11c4);
      ra = '{REG_CONFIG, REG_BASES, REG_SEG_FULL, REG_STATUS, 4'h2};
      rx = '{0, {2'h0, RANGE_RST, 3'h0, LC_BASE_RST, 7'h0, CTRL_BASE_RST}, 0, 0, 0};
      ups = '{'{9'h000, 9'h001, 9'h003, 9'h004, 9'h007, 9'h1ff, 9'h1fe},
              '{9'h01f, 9'h020, 9'h021, 9'h03f, 9'h040, 9'h041, 9'h042}};
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      // Ignored writes
      av(1'b1, 4'h2, 32'hffff_ffff, 4'hf, q);
      av(1'b1, REG_CONFIG, 32'h1, 4'he, q);
      for (k = 0; k < 5; k++) begin
         av(1'b0, ra[k], 32'h0, 4'hf, q);
         chk("reset_value", rx[k], q);
      end
      // Back-to-back polls, then moved bases
      for (k = 0; k < 60; k++) begin
         if (k == 30) begin
            dcbp_sched_model_inst.poll_done();
            av(1'b1, REG_BASES, 32'h1040_0020, 4'hf, q);
            {cb, lb, rg} = {9'h020, 9'h040, 2'h1};
         end
         do_poll({ups[k / 30][$urandom_range(0, 6)], 3'($urandom)}, 1'b0);
      end
      dcbp_sched_model_inst.poll_done();
      // Immediate update: polled mid-cell already full
      exp_full[5] = 1'b1;
      fork
         send_cell(5'h05, 1'b1);
         begin
            repeat (3) @(posedge clk_i);
            do_poll({7'h10, 5'h05}, 1'b0);
            dcbp_sched_model_inst.poll_done();
         end
      join
      av(1'b1, REG_SEG_FULL, 32'h20, 4'hf, q);
      exp_full = 32'h0;
      do_poll({7'h10, 5'h05}, 1'b0);
      dcbp_sched_model_inst.poll_done();
      // Delayed update
      av(1'b1, REG_CONFIG, 32'h1, 4'hf, q);
      send_cell(5'h06, 1'b1);
      av(1'b0, REG_STATUS, 32'h0, 4'hf, q);
      chk("delay_status", 32'h106, q);
      av(1'b0, REG_SEG_FULL, 32'h0, 4'hf, q);
      chk("stale_full", 32'h0, q);
      repeat (6) @(posedge clk_i);
      av(1'b0, REG_SEG_FULL, 32'h0, 4'hf, q);
      chk("late_full", 32'h40, q);
      exp_full[6] = 1'b1;
      do_poll({7'h10, 5'h06}, 1'b0);
      dcbp_sched_model_inst.poll_done();
      av(1'b1, REG_CONFIG, 32'h0, 4'hf, q);
      // Receiver stall
      word_ready_i <= 1'b0;
      fork
         send_cell(5'h09, 1'b0);
         begin
            repeat (8) @(posedge clk_i);
            do_poll({7'h10, 5'h03}, 1'b1);
            dcbp_sched_model_inst.poll_done();
         end
      join
      av(1'b0, REG_STATUS, 32'h0, 4'hf, q);
      chk("overflow", 1'b1, q[STAT_OVF_BIT]);
      word_ready_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("words_left", 32'h0, 32'(wq.size()));
      chk("polls_left", 32'h0, 32'(pq.size()));
      end_sim();
   end
endmodule : test_downstream_cell_bus_polling
